// >>> hw/gpio_pkg.sv
// Purpose: constants shared by the pin block and its bench
// Assumes: 20 pins in four ports, AXI4-Lite register access
// Notes:   byte addresses, one 32-bit word per register
package gpio_pkg;
  localparam int NUM_PINS = 20;
  localparam int NUM_PORTS = 4;
  localparam int CFG_W = 10;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // pin membership of each port; ports 2 and 3 are narrow
  localparam logic [NUM_PINS-1:0] PORT_PINS [NUM_PORTS] =
    '{20'h000FF, 20'h0FF00, 20'h30000, 20'hC0000};

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_OUT_DATA  = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_PIN_STATE = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_INT_STAT  = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_INT_MASK  = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_RISE_EN   = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_FALL_EN   = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_CFG_BASE  = 8'h40;
  localparam logic [ADDR_W-1:0] OFS_CFG_LAST  = 8'h8C;

  // per-pin config word fields
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_MODE_W   = 3;
  localparam int CFG_IN_EN    = 3;
  localparam int CFG_OUT_EN   = 4;
  localparam int CFG_LVTTL    = 5;
  localparam int CFG_SLOW     = 6;
  localparam int CFG_SRC_LSB  = 8;
  localparam int CFG_SRC_W    = 2;

  localparam logic [CFG_W-1:0] CFG_RESET = 10'h000;
  localparam logic [NUM_PINS-1:0] PINS_RESET = 20'h00000;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    DM_ANALOG  = 3'h0,
    DM_INPUT   = 3'h1,
    DM_WUP_SDN = 3'h2,
    DM_SUP_WDN = 3'h3,
    DM_OD_LOW  = 3'h4,
    DM_OD_HIGH = 3'h5,
    DM_STRONG  = 3'h6,
    DM_WEAK    = 3'h7
  } drive_mode_type;

  typedef enum logic [1:0] {
    SRC_SOFT   = 2'h0,
    SRC_PERIPH = 2'h1,
    SRC_SERIAL = 2'h2,
    SRC_SPARE  = 2'h3
  } pin_src_type;
endpackage

// >>> hw/gpio_port.sv
// Purpose: general-purpose pin block with per-pin modes and port interrupts
// Assumes: pad inputs asynchronous to mclk, AXI4-Lite slave at mclk
// Notes:   all pad controls registered, reset leaves every pin disabled
`timescale 1ns/10ps

// Notes on behaviour
// RULE1: twenty pins, each with its own configuration word
// RULE2: eight drive modes decoded per pin into drive and weak pulls
// RULE3: per-pin input threshold select, CMOS or LVTTL
// RULE4: input and output buffer enables separate from the drive mode; analog mode forces the input buffer off
// RULE5: per-pin slow slew select to limit switching noise
// RULE6: pins grouped into ports of up to eight bits, ports 2 and 3 narrower
// RULE7: during reset every pin buffer is held disabled
// RULE8: per-pin source select among software data and peripheral outputs
// RULE9: output data register drives pins, pin state register reads levels
// RULE10: a pin raises an interrupt only while enabled by its mask bit
// RULE11: pin interrupts merge into one request per port, four in total
// RULE12: pins routed to the two-wire serial bus use open-drain drive
// RULE13: pad inputs pass a two-flop synchroniser before any use
// RULE14: sticky per-pin flags set on edges, write one clears
module gpio_port (
  input  wire logic                           mclk,
  input  wire logic                           srst,
  input  wire logic [gpio_pkg::ADDR_W-1:0]    awaddr,
  input  wire logic                           awvalid,
  output logic                                awready,
  input  wire logic [gpio_pkg::DATA_W-1:0]    wdata,
  input  wire logic [3:0]                     wstrb,
  input  wire logic                           wvalid,
  output logic                                wready,
  output logic [1:0]                          bresp,
  output logic                                bvalid,
  input  wire logic                           bready,
  input  wire logic [gpio_pkg::ADDR_W-1:0]    araddr,
  input  wire logic                           arvalid,
  output logic                                arready,
  output logic [gpio_pkg::DATA_W-1:0]         rdata,
  output logic [1:0]                          rresp,
  output logic                                rvalid,
  input  wire logic                           rready,
  input  wire logic [gpio_pkg::NUM_PINS-1:0]  padIn,
  input  wire logic [gpio_pkg::NUM_PINS-1:0]  periphOut,
  input  wire logic [gpio_pkg::NUM_PINS-1:0]  serialOut,
  output logic [gpio_pkg::NUM_PINS-1:0]       padOut,
  output logic [gpio_pkg::NUM_PINS-1:0]       padOeN,
  output logic [gpio_pkg::NUM_PINS-1:0]       padPullUp,
  output logic [gpio_pkg::NUM_PINS-1:0]       padPullDown,
  output logic [gpio_pkg::NUM_PINS-1:0]       padInEn,
  output logic [gpio_pkg::NUM_PINS-1:0]       padLvttl,
  output logic [gpio_pkg::NUM_PINS-1:0]       padSlowSlew,
  output logic [gpio_pkg::NUM_PORTS-1:0]      portIrq,
  output logic                                irq
);
  import gpio_pkg::*;

  // {drive, driveValue, weakUp, weakDown}
  function automatic logic [3:0] drvDecode(input logic [2:0] m, input logic d);
    logic [3:0] r;
    r = 4'h0;
    case (drive_mode_type'(m))
      DM_ANALOG:  r = 4'h0;
      DM_INPUT:   r = 4'h0;
      DM_WUP_SDN: r = d ? 4'h2 : 4'h8;
      DM_SUP_WDN: r = d ? 4'hC : 4'h1;
      DM_OD_LOW:  r = d ? 4'h0 : 4'h8;
      DM_OD_HIGH: r = d ? 4'hC : 4'h0;
      DM_STRONG:  r = {1'b1, d, 2'h0};
      DM_WEAK:    r = {2'h0, d, ~d};
      default:    r = 4'h0;
    endcase
    return r;
  endfunction

  function automatic logic [DATA_W-1:0] byteMerge(input logic [DATA_W-1:0] old,
                                                  input logic [DATA_W-1:0] nw,
                                                  input logic [3:0] strb);
    logic [DATA_W-1:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic isCfg(input logic [ADDR_W-1:0] a);
    return (a >= OFS_CFG_BASE) && (a <= OFS_CFG_LAST) && (a[1:0] == 2'h0);
  endfunction

  logic [CFG_W-1:0]    cfg_ff [NUM_PINS];
  logic [NUM_PINS-1:0] outData_ff;
  logic [NUM_PINS-1:0] intStat_ff;
  logic [NUM_PINS-1:0] intMask_ff;
  logic [NUM_PINS-1:0] riseEn_ff;
  logic [NUM_PINS-1:0] fallEn_ff;
  logic [NUM_PINS-1:0] sync1_ff;
  logic [NUM_PINS-1:0] sync2_ff;
  logic [NUM_PINS-1:0] pinState_ff;
  logic [ADDR_W-1:0]   awAddr_ff;
  logic [DATA_W-1:0]   wData_ff;
  logic [3:0]          wStrb_ff;
  logic                awHeld_ff;
  logic                wHeld_ff;

  // write channel: address and data accepted in any order
  wire                 awTake   = awvalid && awready;
  wire                 wTake    = wvalid && wready;
  wire                 doWrite  = awHeld_ff && wHeld_ff && !bvalid;
  wire [ADDR_W-1:0]    cfgWIdx  = (awAddr_ff - OFS_CFG_BASE) >> 2;
  wire                 wrCfg    = doWrite && isCfg(awAddr_ff);
  wire                 wrOut    = doWrite && (awAddr_ff == OFS_OUT_DATA);
  wire                 wrStat   = doWrite && (awAddr_ff == OFS_INT_STAT);
  wire                 wrMask   = doWrite && (awAddr_ff == OFS_INT_MASK);
  wire                 wrRise   = doWrite && (awAddr_ff == OFS_RISE_EN);
  wire                 wrFall   = doWrite && (awAddr_ff == OFS_FALL_EN);
  wire                 wrState  = awAddr_ff == OFS_PIN_STATE;
  wire                 wrKnown  = isCfg(awAddr_ff) || wrState
                                  || (awAddr_ff == OFS_OUT_DATA) || (awAddr_ff == OFS_INT_STAT)
                                  || (awAddr_ff == OFS_INT_MASK) || (awAddr_ff == OFS_RISE_EN)
                                  || (awAddr_ff == OFS_FALL_EN);
  wire [DATA_W-1:0]    wMerged  = byteMerge({DATA_W{1'b0}}, wData_ff, wStrb_ff);

  // read channel
  wire                 arTake   = arvalid && arready;
  wire [ADDR_W-1:0]    cfgRIdx  = (araddr - OFS_CFG_BASE) >> 2;
  wire [DATA_W-1:0]    rdCfg    = {{(DATA_W-CFG_W){1'b0}}, cfg_ff[cfgRIdx[4:0]]};
  wire [DATA_W-NUM_PINS-1:0] zPad = '0;
  wire                 rdKnown  = isCfg(araddr) || (araddr == OFS_OUT_DATA)
                                  || (araddr == OFS_PIN_STATE) || (araddr == OFS_INT_STAT)
                                  || (araddr == OFS_INT_MASK) || (araddr == OFS_RISE_EN)
                                  || (araddr == OFS_FALL_EN);
  wire [DATA_W-1:0]    rdMux    =
      isCfg(araddr)              ? rdCfg :
      (araddr == OFS_OUT_DATA)   ? {zPad, outData_ff} :
      (araddr == OFS_PIN_STATE)  ? {zPad, pinState_ff} :
      (araddr == OFS_INT_STAT)   ? {zPad, intStat_ff} :
      (araddr == OFS_INT_MASK)   ? {zPad, intMask_ff} :
      (araddr == OFS_RISE_EN)    ? {zPad, riseEn_ff} :
      (araddr == OFS_FALL_EN)    ? {zPad, fallEn_ff} : {DATA_W{1'b0}};

  always_ff @(posedge mclk) begin
    if (srst) begin
      awready   <= 1'b1;
      wready    <= 1'b1;
      awHeld_ff <= 1'b0;
      wHeld_ff  <= 1'b0;
      bvalid    <= 1'b0;
      bresp     <= RESP_OKAY;
      awAddr_ff <= '0;
      wData_ff  <= '0;
      wStrb_ff  <= 4'h0;
    end else begin
      if (awTake) begin
        awAddr_ff <= awaddr;
        awHeld_ff <= 1'b1;
        awready   <= 1'b0;
      end
      if (wTake) begin
        wData_ff <= wdata;
        wStrb_ff <= wstrb;
        wHeld_ff <= 1'b1;
        wready   <= 1'b0;
      end
      if (doWrite) begin
        bvalid <= 1'b1;
        bresp  <= (wrKnown && !wrState) ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid    <= 1'b0;
        awHeld_ff <= 1'b0;
        wHeld_ff  <= 1'b0;
        awready   <= 1'b1;
        wready    <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= RESP_OKAY;
    end else if (arTake) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= rdMux;
      rresp   <= rdKnown ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  wire [DATA_W-1:0]    outMerged  = byteMerge({zPad, outData_ff}, wData_ff, wStrb_ff);
  wire [DATA_W-1:0]    maskMerged = byteMerge({zPad, intMask_ff}, wData_ff, wStrb_ff);
  wire [DATA_W-1:0]    riseMerged = byteMerge({zPad, riseEn_ff}, wData_ff, wStrb_ff);
  wire [DATA_W-1:0]    fallMerged = byteMerge({zPad, fallEn_ff}, wData_ff, wStrb_ff);

  // port-wide registers; byte enables honoured on the low lanes
  always_ff @(posedge mclk) begin
    if (srst) begin
      outData_ff <= PINS_RESET;
      intMask_ff <= PINS_RESET;
      riseEn_ff  <= PINS_RESET;
      fallEn_ff  <= PINS_RESET;
    end else begin
      if (wrOut) begin
        outData_ff <= outMerged[NUM_PINS-1:0]; // [RULE9]
      end
      if (wrMask) begin
        intMask_ff <= maskMerged[NUM_PINS-1:0]; // [RULE10]
      end
      if (wrRise) begin
        riseEn_ff <= riseMerged[NUM_PINS-1:0];
      end
      if (wrFall) begin
        fallEn_ff <= fallMerged[NUM_PINS-1:0];
      end
    end
  end

  // input path: first stage feeds only the second
  always_ff @(posedge mclk) begin
    if (srst) begin
      sync1_ff    <= PINS_RESET;
      sync2_ff    <= PINS_RESET;
      pinState_ff <= PINS_RESET;
    end else begin
      sync1_ff    <= padIn;                 // [RULE13]
      sync2_ff    <= sync1_ff;              // [RULE13]
      pinState_ff <= sync2_ff & padInEn;    // [RULE9]
    end
  end

  wire [NUM_PINS-1:0] levelNow = sync2_ff & padInEn;
  wire [NUM_PINS-1:0] edgeHit  = (levelNow & ~pinState_ff & riseEn_ff)
                                 | (~levelNow & pinState_ff & fallEn_ff);
  wire [NUM_PINS-1:0] clrBits  = wrStat ? wMerged[NUM_PINS-1:0] : PINS_RESET;

  // set wins over a simultaneous write-one clear
  always_ff @(posedge mclk) begin
    if (srst) begin
      intStat_ff <= PINS_RESET;
    end else begin
      intStat_ff <= (intStat_ff & ~clrBits) | (edgeHit & intMask_ff); // [RULE14] [RULE10]
    end
  end

  wire [NUM_PINS-1:0] pendBits = intStat_ff & intMask_ff;

  genvar gp;
  generate
    for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
      always_ff @(posedge mclk) begin
        if (srst) begin
          portIrq[gp] <= 1'b0;
        end else begin
          portIrq[gp] <= |(pendBits & PORT_PINS[gp]); // [RULE11] [RULE6]
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk) begin
    if (srst) begin
      irq <= 1'b0;
    end else begin
      irq <= |pendBits;
    end
  end

  // per-pin configuration and pad control
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
      wire [2:0] modeRaw = cfg_ff[gi][CFG_MODE_LSB +: CFG_MODE_W];
      wire [1:0] src     = cfg_ff[gi][CFG_SRC_LSB +: CFG_SRC_W];
      wire       isSer   = pin_src_type'(src) == SRC_SERIAL;
      wire [2:0] mode    = isSer ? DM_OD_LOW : modeRaw;                   // [RULE12]
      wire       dSel    = (pin_src_type'(src) == SRC_PERIPH) ? periphOut[gi] :
                           isSer ? serialOut[gi] : outData_ff[gi];       // [RULE8]
      wire [3:0] drv     = drvDecode(mode, dSel);                         // [RULE2]
      wire       oEn     = cfg_ff[gi][CFG_OUT_EN];                        // [RULE4]
      wire       iEn     = cfg_ff[gi][CFG_IN_EN] && (mode != DM_ANALOG); // [RULE4]

      always_ff @(posedge mclk) begin
        if (srst) begin
          cfg_ff[gi] <= CFG_RESET;                                        // [RULE1]
        end else if (wrCfg && (cfgWIdx == ADDR_W'(gi))) begin
          cfg_ff[gi] <= wMerged[CFG_W-1:0];
        end
      end

      always_ff @(posedge mclk) begin
        if (srst) begin
          padOeN[gi]      <= 1'b1;                                        // [RULE7]
          padOut[gi]      <= 1'b0;
          padPullUp[gi]   <= 1'b0;
          padPullDown[gi] <= 1'b0;
          padInEn[gi]     <= 1'b0;                                        // [RULE7]
          padLvttl[gi]    <= 1'b0;
          padSlowSlew[gi] <= 1'b0;
        end else begin
          padOeN[gi]      <= !(oEn && drv[3]);
          padOut[gi]      <= drv[2];
          padPullUp[gi]   <= oEn && drv[1];
          padPullDown[gi] <= oEn && drv[0];
          padInEn[gi]     <= iEn;
          padLvttl[gi]    <= cfg_ff[gi][CFG_LVTTL];                       // [RULE3]
          padSlowSlew[gi] <= cfg_ff[gi][CFG_SLOW];                        // [RULE5]
        end
      end
    end
  endgenerate
endmodule

// >>> verif/gpio_pads.sv
// Purpose: external circuitry seen by the pins
// Assumes: external drive never fights a strong device drive
// Notes:   undriven pads toggle every cycle, never hold a level
`timescale 1ns/10ps
module gpio_pads (
  input  wire logic [gpio_pkg::NUM_PINS-1:0] extEn,
  input  wire logic [gpio_pkg::NUM_PINS-1:0] extVal,
  input  wire logic                          mclk,
  input  wire logic [gpio_pkg::NUM_PINS-1:0] padOut,
  input  wire logic [gpio_pkg::NUM_PINS-1:0] padOeN,
  input  wire logic [gpio_pkg::NUM_PINS-1:0] padPullUp,
  input  wire logic [gpio_pkg::NUM_PINS-1:0] padPullDown,
  output logic      [gpio_pkg::NUM_PINS-1:0] padIn
);
  import gpio_pkg::*;
  logic [NUM_PINS-1:0] floatPat = 20'h5A5A5;
  always @(posedge mclk) floatPat <= ~floatPat;
  // outside drive, then strong device drive, then weak pulls
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      padIn[i] = extEn[i] ? extVal[i] : !padOeN[i] ? padOut[i] :
                 padPullUp[i] ? 1'b1 : padPullDown[i] ? 1'b0 : floatPat[i];
    end
  end
endmodule

// >>> verif/gpio_port_chk.sv
// Purpose: port-level checks of the pin block
// Assumes: one clock domain, srst synchronous
// Notes:   bound into every gpio_port
`timescale 1ns/10ps
module gpio_port_chk
  import gpio_pkg::*;
(
  input wire logic                           mclk,
  input wire logic                           srst,
  input wire logic                           awvalid,
  input wire logic                           awready,
  input wire logic                           wvalid,
  input wire logic                           wready,
  input wire logic [1:0]                     bresp,
  input wire logic                           bvalid,
  input wire logic                           bready,
  input wire logic                           arvalid,
  input wire logic                           arready,
  input wire logic [gpio_pkg::DATA_W-1:0]    rdata,
  input wire logic                           rvalid,
  input wire logic                           rready,
  input wire logic [gpio_pkg::NUM_PINS-1:0]  padOeN,
  input wire logic [gpio_pkg::NUM_PINS-1:0]  padPullUp,
  input wire logic [gpio_pkg::NUM_PINS-1:0]  padPullDown,
  input wire logic [gpio_pkg::NUM_PINS-1:0]  padInEn,
  input wire logic [gpio_pkg::NUM_PORTS-1:0] portIrq,
  input wire logic                           irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  property p_reset_off;
    disable iff (1'b0) srst |=> &padOeN && !(|(padInEn | padPullUp | padPullDown));
  endproperty
  a_reset_off: assert property (p_reset_off) else $error("pads active after reset");
  property p_reset_bus;
    disable iff (1'b0) srst |=> awready && wready && arready && !bvalid && !rvalid;
  endproperty
  a_reset_bus: assert property (p_reset_bus) else $error("bus not idle after reset");
  property p_wr_resp;
    awvalid && awready && wvalid && wready |=> ##1 bvalid;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write response late");
  property p_b_stand;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_b_stand: assert property (p_b_stand) else $error("write response dropped");
  property p_rd_resp;
    arvalid && arready |=> rvalid;
  endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("read data late");
  property p_r_stand;
    rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  a_r_stand: assert property (p_r_stand) else $error("read data dropped");
  property p_busy;
    (!bvalid || !awready && !wready) && (!rvalid || !arready);
  endproperty
  a_busy: assert property (p_busy) else $error("ready while answer pending");
  property p_irq_or;
    irq == |portIrq;
  endproperty
  a_irq_or: assert property (p_irq_or) else $error("irq differs from port requests");
  property p_irq_hold;
    |($past(portIrq) & ~portIrq) && !$past(srst) |-> $past(bvalid);
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("port request fell unasked");
  c_irq: cover property ($rose(irq));
  c_wr_err: cover property (bvalid && bready && bresp == RESP_SLVERR);
  c_rd_wait: cover property (rvalid && !rready);
endmodule
bind gpio_port gpio_port_chk i_chk (.mclk, .srst, .awvalid, .awready, .wvalid, .wready,
  .bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rvalid, .rready, .padOeN,
  .padPullUp, .padPullDown, .padInEn, .portIrq, .irq);

// >>> verif/test_gpio_port_with_pin_interrupts.sv
// Purpose: self-checking bench of the pin block
// Assumes: pads model beside the design, AXI4-Lite master tasks
// Notes:   random pins and data from a fixed seed
`timescale 1ns/10ps
module test_gpio_port_with_pin_interrupts import gpio_pkg::*;;
  logic                mclk = 1'b0;
  logic                srst = 1'b1;
  logic                awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic                arvalid = 1'b0, rready = 1'b0;
  logic                awready, wready, bvalid, arready, rvalid, irq;
  logic [ADDR_W-1:0]   awaddr = '0, araddr = '0;
  logic [DATA_W-1:0]   wdata = '0, rdata;
  logic [3:0]          wstrb = 4'hF;
  logic [1:0]          bresp, rresp;
  logic [NUM_PINS-1:0] periphOut = '0, serialOut = '0, extEn = '0, extVal = '0;
  logic [NUM_PINS-1:0] padIn, padOut, padOeN, padPullUp, padPullDown;
  logic [NUM_PINS-1:0] padInEn, padLvttl, padSlowSlew;
  logic [NUM_PORTS-1:0] portIrq;
  logic [31:0]         seed = 32'h38770FBD;
  int                  n_mismatch = 0;
  int                  checked = 0;

  always #12.5 mclk = ~mclk;

  gpio_port i_gpio_port (.mclk, .srst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .padIn, .periphOut, .serialOut, .padOut, .padOeN, .padPullUp, .padPullDown,
    .padInEn, .padLvttl, .padSlowSlew, .portIrq, .irq);
  gpio_pads i_gpio_pads (.mclk, .padOut, .padOeN, .padPullUp, .padPullDown, .extEn,
    .extVal, .padIn);

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // {level defined, level, strong drive} for a mode and data bit
  function automatic logic [2:0] exp_drv(logic [2:0] m, logic d);
    case (m)
      3'h2: return d ? 3'b110 : 3'b101;
      3'h3: return d ? 3'b111 : 3'b100;
      3'h4: return d ? 3'b000 : 3'b101;
      3'h5: return d ? 3'b111 : 3'b000;
      3'h6: return {1'b1, d, 1'b1};
      3'h7: return {1'b1, d, 1'b0};
      default: return 3'b000;
    endcase
  endfunction
  task chk(string n, logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task wr(logic [7:0] a, logic [31:0] d, logic [1:0] er);
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    // ready with the request, or late on a random bit to exercise a wait
    bready <= seed[0];
    do begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid && !bready) bready <= 1'b1;
    end while (!(bvalid && bready));
    bready <= 1'b0;
    chk("bresp", er, bresp);
  endtask
  task rdc(string n, logic [7:0] a, logic [31:0] e, logic [1:0] er = RESP_OKAY);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= seed[1];
    do begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid && !rready) rready <= 1'b1;
    end while (!(rvalid && rready));
    rready <= 1'b0;
    chk(n, e, rdata);
    chk("rresp", er, rresp);
  endtask
  task cfg(int p, logic [31:0] v);
    wr(OFS_CFG_BASE + 8'(4 * p), v, RESP_OKAY);
  endtask
  task end_sim();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    end_sim();
  end

  initial begin
    int p;
    logic [31:0] w;
    logic [2:0] e;
    logic [7:0] ofs [5] = '{OFS_OUT_DATA, OFS_INT_STAT, OFS_INT_MASK, OFS_RISE_EN, OFS_FALL_EN};
    repeat (12) @(posedge mclk);
    srst <= 1'b0;
    extEn <= 20'(rnd());
    extVal <= 20'(rnd());
    @(posedge mclk);
    chk("resetPads", 32'hFFFFF, 32'(padOeN & ~padInEn & ~padPullUp & ~padPullDown));
    chk("resetMisc", 32'h0, 32'(padLvttl | padSlowSlew | padOut) | 32'({irq, portIrq}));
    foreach (ofs[i]) rdc("regReset", ofs[i], 32'h0);
    rdc("pinStateOff", OFS_PIN_STATE, 32'h0);
    rdc("unmapped", 8'h18, 32'h0, RESP_SLVERR);
    wr(OFS_PIN_STATE, 32'hFFFFF, RESP_SLVERR);
    wr(8'h90, rnd(), RESP_SLVERR);
    extEn <= '0;
    for (int m = 0; m < 8; m++) begin
      for (int d = 0; d < 2; d++) begin
        p = rnd() % NUM_PINS;
        w = rnd() & 32'h60;
        cfg(p, w | 32'h18 | 32'(m));
        wr(OFS_OUT_DATA, 32'(d) << p, RESP_OKAY);
        repeat (5) @(posedge mclk);
        e = exp_drv(3'(m), d[0]);
        chk("padOeN", 32'(!e[0]), 32'(padOeN[p]));
        chk("padInEn", 32'(m != 0), 32'(padInEn[p]));
        chk("lvttlSlew", w >> 5, 32'({padSlowSlew[p], padLvttl[p]}));
        if (e[2]) chk("padLevel", 32'(e[1]), 32'(padIn[p]));
        if (m == 0 || e[2]) rdc("pinState", OFS_PIN_STATE, 32'(m != 0 && e[1]) << p);
        cfg(p, 32'h0E);
        repeat (2) @(posedge mclk);
        chk("outOff", 32'h0, 32'({!padOeN[p], padPullUp[p], padPullDown[p]}));
        cfg(p, 32'h0);
      end
    end
    for (int s = 0; s < 4; s++) begin
      p = rnd() % NUM_PINS;
      w = rnd();
      cfg(p, (32'(s) << 8) | 32'h16);
      periphOut <= 20'(rnd());
      serialOut <= 20'(rnd());
      wr(OFS_OUT_DATA, w, RESP_OKAY);
      rdc("outData", OFS_OUT_DATA, w & 32'hFFFFF);
      repeat (4) @(posedge mclk);
      if (s == 2) chk("serialOd", 32'(serialOut[p]), 32'(padOeN[p] | padOut[p]));
      else chk("srcOut", 32'(s == 1 ? periphOut[p] : w[p]), 32'({padOeN[p], padOut[p]}));
      cfg(p, 32'h0);
    end
    extEn <= 20'h50101;
    extVal <= '0;
    foreach (ofs[i]) cfg(i < 3 ? i * 8 : 18, 32'h09);
    wr(OFS_INT_MASK, 32'h10101, RESP_OKAY);
    wr(OFS_RISE_EN, 32'hFFFFF, RESP_OKAY);
    wr(OFS_INT_STAT, 32'hFFFFF, RESP_OKAY);
    @(posedge mclk);
    extVal <= 20'h50101;
    repeat (3) @(posedge mclk);
    #1;
    chk("irqEarly", 32'h0, 32'({irq, portIrq}));
    @(posedge mclk);
    #1;
    chk("irqRise", 32'h17, 32'({irq, portIrq}));
    rdc("intStat", OFS_INT_STAT, 32'h10101);
    wr(OFS_INT_STAT, 32'h100, RESP_OKAY);
    wr(OFS_FALL_EN, 32'h40000, RESP_OKAY);
    wr(OFS_INT_MASK, 32'h50101, RESP_OKAY);
    extVal <= '0;
    repeat (5) @(posedge mclk);
    chk("irqFall", 32'h1D, 32'({irq, portIrq}));
    rdc("intStatFall", OFS_INT_STAT, 32'h50001);
    wr(OFS_INT_STAT, 32'hFFFFF, RESP_OKAY);
    repeat (2) @(posedge mclk);
    chk("irqClear", 32'h0, 32'({irq, portIrq}));
    cfg(5, 32'h16);
    srst <= 1'b1;
    repeat (2) @(posedge mclk);
    chk("midReset", 32'hFFFFF, 32'(padOeN & ~padInEn & ~padPullUp & ~padPullDown));
    srst <= 1'b0;
    repeat (2) @(posedge mclk);
    rdc("cfgAfterReset", OFS_CFG_BASE + 8'h14, 32'h0);
    end_sim();
  end
endmodule
